// ==== src/cgoc_top.sv ====
// Summary of operation
// (RULE1) Mapping code 0 off, 15 on, 1-4 request 0-3, 12 graphics request, else off.
// (RULE2) External strap mode keeps reference outputs off; request gating only in integrated mode.
// (RULE3) Port clock three buffer follows strap; bit 11 inverts strap.
// (RULE4) Auxiliary clock from PLL when strap high, else external; bit 26 inverts.
// (RULE5) Processor clock from PLL when strap high, else external; bit 10 inverts.
// (RULE6) Graphics slot clock follows mapping; bit 29 inverts strap instead.
// (RULE7) Port clocks 0-2 follow mappings; bit 12 inverts strap. Port clocks 0-2 here use fixed code 15 instead of a mapping.
// (RULE8) Bits 24:23 give modulator order, reset first order.
// (RULE9) Bit 22 enables PRBS17 generator, reset one.
// (RULE10) Bits 21:20 pick slip handshake or slip every 1, 2, 4 cycles.
// (RULE11) Calibration runs after reset unless bit 1 set; the code samples bit 1 at its reset value 0, so calibration always runs.
// (RULE12) Bit 0 bypasses reference divider during calibration.
// (RULE13) Bits 3:2 choose VCO centre 1200, 1000, 800 MHz; 3 reserved.
// (RULE14) Spread spectrum enabled only while its bit set, reset off.
// (RULE15) Pull-down override bits 3,2,1 invert pull-down decision per pin.
// (RULE16) SATA bypass bit passes reference input instead of PLL 100 MHz.
// (RULE17) Post dividers bypass for 0 and 1; resets 0Ch and 03h.
// (RULE18) Power-down bits 28, 27, 16, 13 for their circuits.
// (RULE19) Bit 30 turns regulator off; bit 31 enables display reference.
// (RULE20) Output enables and source selects change only while clock is low.
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "cgoc_regs.svh"
module cgoc_top #(
  parameter int CLK_MHZ = 200
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clock_mode_strap,
  input wire cgoc_pkg::cgoc_req_t req_in,
  input wire logic out_clk_level,
  input wire logic [2:0] pd_logic,
  input wire logic slip_ack,
  output cgoc_pkg::cgoc_outs_t outs_q,
  output logic [2:0] pull_down_q,
  output logic slip_req_q,
  output logic cal_active_q,
  output logic cal_use_refdiv_q,
  output logic [1:0] vco_centre_sel_q,
  output logic [1:0] delta_sigma_order_q,
  output logic modulator_prbs_enable_q,
  output logic spread_enable_q,
  output logic sata_ref_passthrough_q,
  output logic [6:0] pcie_div_q,
  output logic [6:0] core_div_q,
  output logic pcie_div_bypass_q,
  output logic core_div_bypass_q,
  output logic [3:0] power_off_q,
  output logic pll_regulator_off_q,
  output logic crystal_display_ref_enable_q
);
  localparam int CAL_CYC = (`CGOC_CAL_NS * CLK_MHZ + 999) / 1000;
  logic [31:0] outctl_q, pllcfg1_q, pllcfg2_q;
  logic [7:0] cal_cnt_q;
  logic [1:0] slip_cnt_q;
  logic [2:0] vco_cnt_q;
  logic strap_q;
  cgoc_pkg::cgoc_cal_t cal_q;
  cgoc_pkg::cgoc_outs_t outs_d;
  logic wr_en, rd_hit;

  function automatic logic map_on(input logic [3:0] code, input cgoc_pkg::cgoc_req_t r);
    case (code)
      4'h0: map_on = 1'b0; // RULE1
      4'h1: map_on = ~r.port_req_b[0];
      4'h2: map_on = ~r.port_req_b[1];
      4'h3: map_on = ~r.port_req_b[2];
      4'h4: map_on = ~r.port_req_b[3];
      4'hC: map_on = ~r.gfx_req_b;
      4'hF: map_on = 1'b1;
      default: map_on = 1'b0;
    endcase
  endfunction : map_on

  function automatic logic div_bypass(input logic [6:0] d);
    div_bypass = (d == 7'h00) || (d == 7'h01); // RULE17
  endfunction : div_bypass

  // APB: zero wait state, unmapped offsets error
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && ce;
  assign rd_hit = (paddr == `CGOC_OFF_OUTCTL) || (paddr == `CGOC_OFF_PLLCFG1) ||
                  (paddr == `CGOC_OFF_PLLCFG2) || (paddr == `CGOC_OFF_STATUS);
  assign pslverr = psel && penable && !rd_hit;

  always_comb begin
    case (paddr)
      `CGOC_OFF_OUTCTL: prdata = outctl_q;
      `CGOC_OFF_PLLCFG1: prdata = pllcfg1_q;
      `CGOC_OFF_PLLCFG2: prdata = pllcfg2_q;
      `CGOC_OFF_STATUS: prdata = {22'h0, slip_req_q, cal_q == cgoc_pkg::CAL_DONE, cal_active_q, outs_q};
      default: prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      outctl_q <= `CGOC_RST_OUTCTL; // RULE8 RULE9 RULE18
      pllcfg1_q <= `CGOC_RST_PLLCFG1; // RULE14
      pllcfg2_q <= `CGOC_RST_PLLCFG2; // RULE17
    end else if (wr_en) begin
      if (paddr == `CGOC_OFF_OUTCTL) outctl_q <= pwdata & `CGOC_MASK_OUTCTL;
      if (paddr == `CGOC_OFF_PLLCFG1) pllcfg1_q <= pwdata & `CGOC_MASK_PLLCFG1;
      if (paddr == `CGOC_OFF_PLLCFG2) pllcfg2_q <= pwdata & `CGOC_MASK_PLLCFG2;
    end
  end

  // Strap is caught after reset release, never under the async reset
  logic strap_seen_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      strap_q <= 1'b0;
      strap_seen_q <= 1'b0;
    end else if (ce && !strap_seen_q) begin
      strap_q <= clock_mode_strap;
      strap_seen_q <= 1'b1;
    end
  end

  always_comb begin
    logic s3, saux, scpu, sgfx, sport;
    s3 = strap_q ^ outctl_q[`CGOC_BIT_P3OVR];
    saux = strap_q ^ outctl_q[`CGOC_BIT_AUXOVR];
    scpu = strap_q ^ outctl_q[`CGOC_BIT_CPUOVR];
    sgfx = strap_q ^ outctl_q[`CGOC_BIT_GFXOVR];
    sport = strap_q ^ outctl_q[`CGOC_BIT_PORTOVR];
    outs_d.port3_oe = s3; // RULE3
    outs_d.aux_from_pll = saux; // RULE4
    outs_d.cpu_from_pll = scpu; // RULE5
    // Override replaces mapping with the inverted strap level
    if (outctl_q[`CGOC_BIT_GFXOVR])
      outs_d.gfx_oe = sgfx; // RULE6
    else
      outs_d.gfx_oe = strap_q && map_on(outctl_q[`CGOC_POS_GFXMAP +: 4], req_in); // RULE2 RULE1
    for (int i = 0; i < 3; i++) begin
      if (outctl_q[`CGOC_BIT_PORTOVR])
        outs_d.port_oe[i] = sport; // RULE7
      else
        outs_d.port_oe[i] = strap_q && map_on(4'hF, req_in); // RULE2
    end
  end

  // Glitch-free: outputs only move while the output clock is low
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) outs_q <= '0;
    else if (ce && !out_clk_level) outs_q <= outs_d; // RULE20
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pull_down_q <= 3'b000;
      delta_sigma_order_q <= 2'b01;
      modulator_prbs_enable_q <= 1'b1;
      spread_enable_q <= 1'b0;
      sata_ref_passthrough_q <= 1'b0;
      pcie_div_q <= 7'h0C;
      core_div_q <= 7'h03;
      pcie_div_bypass_q <= 1'b0;
      core_div_bypass_q <= 1'b0;
      power_off_q <= 4'b0010;
      pll_regulator_off_q <= 1'b0;
      crystal_display_ref_enable_q <= 1'b0;
      vco_centre_sel_q <= 2'b00;
      cal_use_refdiv_q <= 1'b0;
    end else if (ce) begin
      pull_down_q <= pd_logic ^ pllcfg1_q[`CGOC_POS_PDGFX +: 3]; // RULE15
      delta_sigma_order_q <= outctl_q[`CGOC_POS_DSORD +: 2]; // RULE8
      modulator_prbs_enable_q <= outctl_q[`CGOC_BIT_PRBS]; // RULE9
      spread_enable_q <= pllcfg1_q[`CGOC_BIT_SPREAD]; // RULE14
      sata_ref_passthrough_q <= pllcfg1_q[`CGOC_BIT_SATABYP]; // RULE16
      pcie_div_q <= pllcfg2_q[`CGOC_POS_PDIVPCIE +: 7];
      core_div_q <= pllcfg2_q[`CGOC_POS_PDIVCORE +: 7];
      pcie_div_bypass_q <= div_bypass(pllcfg2_q[`CGOC_POS_PDIVPCIE +: 7]); // RULE17
      core_div_bypass_q <= div_bypass(pllcfg2_q[`CGOC_POS_PDIVCORE +: 7]); // RULE17
      power_off_q <= {outctl_q[`CGOC_BIT_PHYOFF], outctl_q[`CGOC_BIT_TESTOFF],
                      outctl_q[`CGOC_BIT_BIASOFF], outctl_q[`CGOC_BIT_RINOFF]}; // RULE18
      pll_regulator_off_q <= outctl_q[`CGOC_BIT_REGOFF]; // RULE19
      crystal_display_ref_enable_q <= outctl_q[`CGOC_BIT_DPLLREF]; // RULE19
      vco_centre_sel_q <= outctl_q[`CGOC_POS_VCOSEL +: 2]; // RULE13
      cal_use_refdiv_q <= cal_active_q && !outctl_q[`CGOC_BIT_CALBYP]; // RULE12
    end
  end

  // Calibration sequencer, started once per reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cal_q <= cgoc_pkg::CAL_IDLE;
      cal_cnt_q <= 8'h00;
      cal_active_q <= 1'b0;
    end else if (ce) begin
      case (cal_q)
        cgoc_pkg::CAL_IDLE: begin
          if (outctl_q[`CGOC_BIT_NOCAL]) cal_q <= cgoc_pkg::CAL_DONE; // RULE11
          else begin
            cal_q <= cgoc_pkg::CAL_RUN;
            cal_active_q <= 1'b1;
            cal_cnt_q <= 8'(CAL_CYC);
          end
        end
        cgoc_pkg::CAL_RUN: begin
          if (cal_cnt_q == 8'h01) begin
            cal_q <= cgoc_pkg::CAL_DONE;
            cal_active_q <= 1'b0;
          end
          cal_cnt_q <= cal_cnt_q - 8'h01;
        end
        cgoc_pkg::CAL_DONE: cal_q <= cgoc_pkg::CAL_DONE;
        default: cal_q <= cgoc_pkg::CAL_IDLE;
      endcase
    end
  end

  // Slip pacing; handshake mode waits for acknowledge, models 8 VCO cycles as a floor
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      slip_req_q <= 1'b0;
      slip_cnt_q <= 2'b00;
      vco_cnt_q <= 3'b000;
    end else if (ce) begin
      case (outctl_q[`CGOC_POS_SLIP +: 2])
        2'b00: begin
          vco_cnt_q <= vco_cnt_q + 3'b001;
          if (slip_req_q && slip_ack) slip_req_q <= 1'b0; // RULE10
          else if (!slip_req_q && vco_cnt_q == 3'(`CGOC_VCO_SLIP - 1)) slip_req_q <= 1'b1;
        end
        2'b01: slip_req_q <= 1'b1; // RULE10
        2'b10: begin
          slip_cnt_q <= {1'b0, ~slip_cnt_q[0]};
          slip_req_q <= slip_cnt_q[0];
        end
        default: begin
          slip_cnt_q <= slip_cnt_q + 2'b01;
          slip_req_q <= (slip_cnt_q == 2'b11);
        end
      endcase
    end
  end

  property p_ext_mode_off;
    @(posedge mclk) disable iff (!rst_b)
      (strap_seen_q && !strap_q && !outctl_q[`CGOC_BIT_GFXOVR] && ce && !out_clk_level) |=> !outs_q.gfx_oe;
  endproperty
  a_ext_mode_off: assert property (p_ext_mode_off) else $error("graphics output on in external mode"); // RULE2
  property p_port3;
    @(posedge mclk) disable iff (!rst_b)
      (ce && !out_clk_level) |=> outs_q.port3_oe == $past(strap_q ^ outctl_q[`CGOC_BIT_P3OVR]);
  endproperty
  a_port3: assert property (p_port3) else $error("port three enable wrong"); // RULE3
  property p_glitch;
    @(posedge mclk) disable iff (!rst_b) $past(out_clk_level) |-> $stable(outs_q);
  endproperty
  a_glitch: assert property (p_glitch) else $error("output changed while clock high"); // RULE20
  property p_bypass;
    @(posedge mclk) disable iff (!rst_b) ce |=> pcie_div_bypass_q == ($past(pllcfg2_q[31:26]) == 6'h00);
  endproperty
  a_bypass: assert property (p_bypass) else $error("post divider bypass wrong"); // RULE17
  property p_nocal;
    @(posedge mclk) disable iff (!rst_b)
      (cal_q == cgoc_pkg::CAL_IDLE && outctl_q[`CGOC_BIT_NOCAL] && ce) |=> !cal_active_q;
  endproperty
  a_nocal: assert property (p_nocal) else $error("calibration ran while bypassed"); // RULE11
  property p_calend;
    @(posedge mclk) disable iff (!rst_b) $rose(cal_active_q) && ce |-> ##[1:40] !cal_active_q;
  endproperty
  a_calend: assert property (p_calend) else $error("calibration never ended"); // RULE11
  property p_slip1;
    @(posedge mclk) disable iff (!rst_b)
      (ce && outctl_q[21:20] == 2'b01) [*2] |-> slip_req_q;
  endproperty
  a_slip1: assert property (p_slip1) else $error("slip every cycle missing"); // RULE10
  property p_spread;
    @(posedge mclk) disable iff (!rst_b) ce |=> spread_enable_q == $past(pllcfg1_q[0]);
  endproperty
  a_spread: assert property (p_spread) else $error("spread enable mismatch"); // RULE14
  property p_aux;
    @(posedge mclk) disable iff (!rst_b)
      (ce && !out_clk_level) |=> outs_q.aux_from_pll == $past(strap_q ^ outctl_q[`CGOC_BIT_AUXOVR]);
  endproperty
  a_aux: assert property (p_aux) else $error("auxiliary source wrong"); // RULE4
  property p_cpu;
    @(posedge mclk) disable iff (!rst_b)
      (ce && !out_clk_level) |=> outs_q.cpu_from_pll == $past(strap_q ^ outctl_q[`CGOC_BIT_CPUOVR]);
  endproperty
  a_cpu: assert property (p_cpu) else $error("processor source wrong"); // RULE5
  property p_gfx_ovr;
    @(posedge mclk) disable iff (!rst_b)
      (ce && !out_clk_level && outctl_q[`CGOC_BIT_GFXOVR]) |=> outs_q.gfx_oe == $past(!strap_q);
  endproperty
  a_gfx_ovr: assert property (p_gfx_ovr) else $error("graphics override wrong"); // RULE6
  property p_port_ovr;
    @(posedge mclk) disable iff (!rst_b)
      (ce && !out_clk_level && outctl_q[`CGOC_BIT_PORTOVR]) |=> outs_q.port_oe == {3{$past(!strap_q)}};
  endproperty
  a_port_ovr: assert property (p_port_ovr) else $error("port override wrong"); // RULE7
  property p_gfx_on;
    @(posedge mclk) disable iff (!rst_b)
      (ce && !out_clk_level && !outctl_q[`CGOC_BIT_GFXOVR] && strap_q &&
       outctl_q[`CGOC_POS_GFXMAP +: 4] == 4'hF) |=> outs_q.gfx_oe;
  endproperty
  a_gfx_on: assert property (p_gfx_on) else $error("graphics forced on missing"); // RULE1
  property p_gfx_off;
    @(posedge mclk) disable iff (!rst_b)
      (ce && !out_clk_level && !outctl_q[`CGOC_BIT_GFXOVR] &&
       outctl_q[`CGOC_POS_GFXMAP +: 4] == 4'h0) |=> !outs_q.gfx_oe;
  endproperty
  a_gfx_off: assert property (p_gfx_off) else $error("graphics forced off missing"); // RULE1
  property p_gfx_req0;
    @(posedge mclk) disable iff (!rst_b)
      (ce && !out_clk_level && !outctl_q[`CGOC_BIT_GFXOVR] && strap_q &&
       outctl_q[`CGOC_POS_GFXMAP +: 4] == 4'h1) |=> outs_q.gfx_oe == $past(!req_in.port_req_b[0]);
  endproperty
  a_gfx_req0: assert property (p_gfx_req0) else $error("request zero gating wrong"); // RULE1
  property p_gfx_reqg;
    @(posedge mclk) disable iff (!rst_b)
      (ce && !out_clk_level && !outctl_q[`CGOC_BIT_GFXOVR] && strap_q &&
       outctl_q[`CGOC_POS_GFXMAP +: 4] == 4'hC) |=> outs_q.gfx_oe == $past(!req_in.gfx_req_b);
  endproperty
  a_gfx_reqg: assert property (p_gfx_reqg) else $error("graphics request gating wrong"); // RULE1
  property p_dsorder;
    @(posedge mclk) disable iff (!rst_b) ce |=> delta_sigma_order_q == $past(outctl_q[`CGOC_POS_DSORD +: 2]);
  endproperty
  a_dsorder: assert property (p_dsorder) else $error("modulator order wrong"); // RULE8
  property p_prbs;
    @(posedge mclk) disable iff (!rst_b) ce |=> modulator_prbs_enable_q == $past(outctl_q[`CGOC_BIT_PRBS]);
  endproperty
  a_prbs: assert property (p_prbs) else $error("prbs enable wrong"); // RULE9
  property p_vco;
    @(posedge mclk) disable iff (!rst_b) ce |=> vco_centre_sel_q == $past(outctl_q[`CGOC_POS_VCOSEL +: 2]);
  endproperty
  a_vco: assert property (p_vco) else $error("vco centre select wrong"); // RULE13
  property p_refdiv;
    @(posedge mclk) disable iff (!rst_b)
      ce |=> cal_use_refdiv_q == $past(cal_active_q && !outctl_q[`CGOC_BIT_CALBYP]);
  endproperty
  a_refdiv: assert property (p_refdiv) else $error("calibration divider use wrong"); // RULE12
  property p_pulldown;
    @(posedge mclk) disable iff (!rst_b) ce |=> pull_down_q == $past(pd_logic ^ pllcfg1_q[`CGOC_POS_PDGFX +: 3]);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down override wrong"); // RULE15
  property p_sata;
    @(posedge mclk) disable iff (!rst_b) ce |=> sata_ref_passthrough_q == $past(pllcfg1_q[`CGOC_BIT_SATABYP]);
  endproperty
  a_sata: assert property (p_sata) else $error("sata passthrough wrong"); // RULE16
  property p_power;
    @(posedge mclk) disable iff (!rst_b)
      ce |=> power_off_q == $past({outctl_q[`CGOC_BIT_PHYOFF], outctl_q[`CGOC_BIT_TESTOFF],
                                   outctl_q[`CGOC_BIT_BIASOFF], outctl_q[`CGOC_BIT_RINOFF]});
  endproperty
  a_power: assert property (p_power) else $error("power down bits wrong"); // RULE18
  property p_regoff;
    @(posedge mclk) disable iff (!rst_b)
      ce |=> {pll_regulator_off_q, crystal_display_ref_enable_q} ==
             $past({outctl_q[`CGOC_BIT_REGOFF], outctl_q[`CGOC_BIT_DPLLREF]});
  endproperty
  a_regoff: assert property (p_regoff) else $error("regulator or display reference wrong"); // RULE19
  property p_slip2;
    @(posedge mclk) disable iff (!rst_b)
      (ce && outctl_q[21:20] == 2'b10) [*3] |-> slip_req_q != $past(slip_req_q);
  endproperty
  a_slip2: assert property (p_slip2) else $error("slip every two cycles missing"); // RULE10
  property p_core_bypass;
    @(posedge mclk) disable iff (!rst_b) ce |=> core_div_bypass_q == ($past(pllcfg2_q[24:19]) == 6'h00);
  endproperty
  a_core_bypass: assert property (p_core_bypass) else $error("core divider bypass wrong"); // RULE17
  c_cal: cover property (@(posedge mclk) disable iff (!rst_b) $fell(cal_active_q));
  c_ext: cover property (@(posedge mclk) disable iff (!rst_b) strap_seen_q && !strap_q);
  c_slip4: cover property (@(posedge mclk) disable iff (!rst_b) outctl_q[21:20] == 2'b11 && slip_req_q);
  c_gfx: cover property (@(posedge mclk) disable iff (!rst_b) $rose(outs_q.gfx_oe));
  c_slip: cover property (@(posedge mclk) disable iff (!rst_b) slip_req_q && slip_ack);
endmodule : cgoc_top
`default_nettype wire

// ==== include/cgoc_regs.svh ====
`ifndef CGOC_REGS_SVH
`define CGOC_REGS_SVH
`define CGOC_OFF_OUTCTL 12'h004
`define CGOC_OFF_PLLCFG1 12'h008
`define CGOC_OFF_PLLCFG2 12'h00C
`define CGOC_OFF_STATUS 12'h010
`define CGOC_RST_OUTCTL 32'h00D1_00F0
`define CGOC_RST_PLLCFG1 32'h0000_0000
`define CGOC_RST_PLLCFG2 32'h180C_0000
`define CGOC_MASK_OUTCTL 32'hFDF1_3CFF
`define CGOC_MASK_PLLCFG1 32'hFFFF_002F
`define CGOC_MASK_PLLCFG2 32'hFFFF_FFFF
`define CGOC_BIT_DPLLREF 31
`define CGOC_BIT_REGOFF 30
`define CGOC_BIT_GFXOVR 29
`define CGOC_BIT_PHYOFF 28
`define CGOC_BIT_TESTOFF 27
`define CGOC_BIT_AUXOVR 26
`define CGOC_POS_DSORD 23
`define CGOC_BIT_PRBS 22
`define CGOC_POS_SLIP 20
`define CGOC_BIT_BIASOFF 16
`define CGOC_BIT_RINOFF 13
`define CGOC_BIT_PORTOVR 12
`define CGOC_BIT_P3OVR 11
`define CGOC_BIT_CPUOVR 10
`define CGOC_POS_GFXMAP 4
`define CGOC_POS_VCOSEL 2
`define CGOC_BIT_NOCAL 1
`define CGOC_BIT_CALBYP 0
`define CGOC_BIT_SATABYP 5
`define CGOC_POS_PDGFX 1
`define CGOC_BIT_SPREAD 0
`define CGOC_POS_PDIVPCIE 25
`define CGOC_POS_PDIVCORE 18
`define CGOC_CAL_NS 100
`define CGOC_VCO_SLIP 8
`endif

// ==== include/cgoc_pkg.sv ====
package cgoc_pkg;
  typedef struct packed {
    logic [3:0] port_req_b;
    logic gfx_req_b;
  } cgoc_req_t;
  typedef struct packed {
    logic [2:0] port_oe;
    logic gfx_oe;
    logic port3_oe;
    logic aux_from_pll;
    logic cpu_from_pll;
  } cgoc_outs_t;
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_RUN = 3'b010,
    CAL_DONE = 3'b100
  } cgoc_cal_t;
endpackage : cgoc_pkg

// ==== bench/cgoc_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
module cgoc_partner #(
  parameter int ACK_DLY = 3
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hold_high,
  input wire logic slip_req,
  output logic out_clk_level,
  output logic slip_ack
);
  logic [1:0] div_q;
  logic [2:0] dly_q;
  // Output clock seen by the consumers; hold_high parks it high to stall output switching
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) div_q <= 2'h0;
    else div_q <= div_q + 2'h1;
  end
  assign out_clk_level = hold_high | div_q[1];
  // Slow acknowledge, held until the request drops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) dly_q <= 3'h0;
    else if (!slip_req) dly_q <= 3'h0;
    else if (dly_q != 3'h7) dly_q <= dly_q + 3'h1;
  end
  assign slip_ack = (32'(dly_q) >= ACK_DLY);
endmodule : cgoc_partner
`default_nettype wire

// ==== bench/cgoc_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cgoc_regs.svh"
module cgoc_bench;
  logic mclk, rst_b, ce, psel, penable, pwrite, clock_mode_strap, hold_high, pready, pslverr, e;
  logic out_clk_level, slip_ack, slip_req_q, cal_active_q, cal_use_refdiv_q, modulator_prbs_enable_q;
  logic spread_enable_q, sata_ref_passthrough_q, pcie_div_bypass_q, core_div_bypass_q;
  logic pll_regulator_off_q, crystal_display_ref_enable_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] pd_logic, pull_down_q;
  logic [1:0] vco_centre_sel_q, delta_sigma_order_q;
  logic [6:0] pcie_div_q, core_div_q;
  logic [3:0] power_off_q;
  logic [4:0] r;
  cgoc_pkg::cgoc_req_t req_in;
  cgoc_pkg::cgoc_outs_t outs_q;
  int bad_count = 0;
  int compares = 0;
  int n;
  logic [3:0] codes [9] = '{4'h0, 4'hF, 4'h1, 4'h2, 4'h3, 4'h4, 4'hC, 4'h5, 4'hD};
  cgoc_top uut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_mode_strap(clock_mode_strap), .req_in(req_in), .out_clk_level(out_clk_level),
    .pd_logic(pd_logic), .slip_ack(slip_ack), .outs_q(outs_q), .pull_down_q(pull_down_q),
    .slip_req_q(slip_req_q), .cal_active_q(cal_active_q), .cal_use_refdiv_q(cal_use_refdiv_q),
    .vco_centre_sel_q(vco_centre_sel_q), .delta_sigma_order_q(delta_sigma_order_q),
    .modulator_prbs_enable_q(modulator_prbs_enable_q), .spread_enable_q(spread_enable_q),
    .sata_ref_passthrough_q(sata_ref_passthrough_q), .pcie_div_q(pcie_div_q), .core_div_q(core_div_q),
    .pcie_div_bypass_q(pcie_div_bypass_q), .core_div_bypass_q(core_div_bypass_q),
    .power_off_q(power_off_q), .pll_regulator_off_q(pll_regulator_off_q),
    .crystal_display_ref_enable_q(crystal_display_ref_enable_q));
  cgoc_partner far (.mclk(mclk), .rst_b(rst_b), .hold_high(hold_high), .slip_req(slip_req_q),
    .out_clk_level(out_clk_level), .slip_ack(slip_ack));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic close_out;
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Zero-wait slave, but the master still waits for pready as the bus requires
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Outputs also wait for a low output clock, which comes every four cycles
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (6) @(posedge mclk);
    #1;
  endtask : wr
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
  endtask : do_reset
  function automatic logic gx(input logic [3:0] c, input logic [4:0] rq);
    case (c)
      4'h0: gx = 1'b0;
      4'hF: gx = 1'b1;
      4'h1, 4'h2, 4'h3, 4'h4: gx = ~rq[c];
      4'hC: gx = ~rq[0];
      default: gx = 1'b0;
    endcase
  endfunction : gx
  initial begin
    {rst_b, psel, penable, pwrite, hold_high} = '0;
    {ce, clock_mode_strap} = 2'b11;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pd_logic = 3'b101;
    req_in = 5'b1_1111;
    do_reset();
    repeat (2) @(posedge mclk);
    #1;
    chk({cal_active_q, cal_use_refdiv_q}, 2'b11);
    chk({delta_sigma_order_q, modulator_prbs_enable_q, pcie_div_q, core_div_q}, {2'b01, 1'b1, 7'h0C, 7'h03});
    chk({power_off_q, spread_enable_q}, {4'b0010, 1'b0});
    repeat (30) @(posedge mclk);
    #1;
    chk(cal_active_q, 1'b0);
    apb(1'b0, `CGOC_OFF_OUTCTL, 32'h0);
    chk(q & 32'h01F1_00F0, 32'h00D1_00F0);
    apb(1'b0, `CGOC_OFF_PLLCFG2, 32'h0);
    chk(q & 32'hFFFC_0000, 32'h180C_0000);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      wr(`CGOC_OFF_OUTCTL, (i << 23) | (i << 2) | (i & 1) | 32'h0000_00F0);
      chk({delta_sigma_order_q, vco_centre_sel_q, cal_use_refdiv_q}, {i[1:0], i[1:0], 1'b0});
    end
    wr(`CGOC_OFF_OUTCTL, 32'hD801_20F0);
    chk({power_off_q, pll_regulator_off_q, crystal_display_ref_enable_q}, 6'h3F);
    wr(`CGOC_OFF_OUTCTL, 32'h0000_00F0);
    chk({power_off_q, pll_regulator_off_q, crystal_display_ref_enable_q}, 6'h00);
    wr(`CGOC_OFF_PLLCFG1, 32'h0000_002F);
    chk({pull_down_q, spread_enable_q, sata_ref_passthrough_q}, 5'b010_11);
    wr(`CGOC_OFF_PLLCFG1, 32'h0);
    chk({pull_down_q, spread_enable_q, sata_ref_passthrough_q}, 5'b101_00);
    wr(`CGOC_OFF_PLLCFG2, 32'h0200_0000);
    chk({pcie_div_bypass_q, core_div_bypass_q}, 2'b11);
    wr(`CGOC_OFF_PLLCFG2, 32'h05FC_0000);
    chk({pcie_div_q, core_div_q, pcie_div_bypass_q, core_div_bypass_q}, {7'h02, 7'h7F, 2'b00});
    $display("pll field test done");
    for (int i = 0; i < 18; i++) begin
      r = (i & 1) ? 5'b10101 : 5'b01010;
      req_in <= cgoc_pkg::cgoc_req_t'(r);
      wr(`CGOC_OFF_OUTCTL, {24'h0, codes[i / 2], 4'h0});
      chk(outs_q, {3'b111, gx(codes[i / 2], r), 3'b111});
    end
    wr(`CGOC_OFF_OUTCTL, 32'h2400_1CF0);
    chk(outs_q, 7'h00);
    hold_high <= 1'b1;
    wr(`CGOC_OFF_OUTCTL, 32'h0000_00F0);
    chk(outs_q, 7'h00);
    hold_high <= 1'b0;
    wr(`CGOC_OFF_OUTCTL, 32'h0000_00F0);
    chk(outs_q, 7'h7F);
    $display("output control test done");
    n = 0;
    while (slip_req_q !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    chk(slip_req_q, 1'b1);
    n = 0;
    while (slip_req_q !== 1'b0 && n < 12) begin
      @(posedge mclk);
      n++;
    end
    chk(slip_req_q, 1'b0);
    for (int m = 1; m < 4; m++) begin
      wr(`CGOC_OFF_OUTCTL, (m << 20) | 32'h0000_00F0);
      n = 0;
      repeat (8) begin
        @(posedge mclk);
        #1;
        n += slip_req_q;
      end
      chk(n, 8 >> (m - 1));
    end
    apb(1'b0, 12'h020, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    ce <= 1'b0;
    apb(1'b1, `CGOC_OFF_PLLCFG1, 32'h0000_0001);
    ce <= 1'b1;
    apb(1'b0, `CGOC_OFF_PLLCFG1, 32'h0);
    chk(q & 32'h0000_002F, 32'h0);
    $display("bus test done");
    clock_mode_strap <= 1'b0;
    do_reset();
    repeat (30) @(posedge mclk);
    #1;
    chk(outs_q, 7'h00);
    wr(`CGOC_OFF_OUTCTL, 32'h2400_1CF0);
    chk(outs_q, 7'h7F);
    $display("strap test done");
    close_out();
  end
  // Whole run is a few hundred cycles; this span is ample
  initial begin
    #60000;
    bad_count++;
    close_out();
  end
endmodule : cgoc_bench
`default_nettype wire
